//--- logic/rtc_regs.svh
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

// Command codes, first byte after select rises
`define RTC_CMD_TIME_WR   8'h01
`define RTC_CMD_TIME_RD   8'h02
`define RTC_CMD_ALARM_WR  8'h03
`define RTC_CMD_CTRL_WR   8'h04

// Data bytes that follow each command
`define RTC_TIME_BYTES    3'd7
`define RTC_ALARM_BYTES   3'd2
`define RTC_CTRL_BYTES    3'd1

// Byte index of each field in a time transfer
`define RTC_IDX_YEAR      3'd0
`define RTC_IDX_MONTH     3'd1
`define RTC_IDX_DAY       3'd2
`define RTC_IDX_WDAY      3'd3
`define RTC_IDX_HOUR      3'd4
`define RTC_IDX_MIN       3'd5
`define RTC_IDX_SEC       3'd6

// Control byte: alarm interrupt enable bit
`define RTC_CTRL_AIE_BIT  0

// Timekeeping: one second, in ns, and its count of ref_clk cycles
`define RTC_SEC_NS        1000000000
`define RTC_CLK_NS        4
`define RTC_SEC_CYCLES    (`RTC_SEC_NS / `RTC_CLK_NS)

`endif

//--- logic/rtc_pkg.sv
`default_nettype none
package rtc_pkg;

  // Calendar and time, all fields BCD
  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] day;
    logic [7:0] wday;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } rtc_time_t;

  // Serial frame progress
  typedef enum logic [1:0] {
    RTC_ST_IDLE,
    RTC_ST_CMD,
    RTC_ST_DATA,
    RTC_ST_DONE
  } rtc_state_t;

endpackage : rtc_pkg

`default_nettype wire

//--- logic/rtc_bcd_counter.sv
`timescale 1ns/1ps
`default_nettype none

module rtc_bcd_counter (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       inc,
  input  wire logic       clr,
  input  wire logic       load,
  input  wire logic [7:0] ld_val,
  input  wire logic [7:0] min_val,
  input  wire logic [7:0] max_val,
  output logic      [7:0] q,
  output logic            wrap
);

  // Carry out when stepping past the limit
  assign wrap = inc && (q == max_val);

  // **********************
  // BCD field register
  // **********************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q <= 8'h00;
    end else if (clr) begin
      q <= 8'h00;
    end else if (load) begin
      q <= ld_val;
    end else if (inc) begin
      if (q == max_val) begin
        q <= min_val;
      end else if (q[3:0] == 4'h9) begin
        q <= {q[7:4] + 4'h1, 4'h0};
      end else begin
        q <= {q[7:4], q[3:0] + 4'h1};
      end
    end
  end

endmodule : rtc_bcd_counter

`default_nettype wire

//--- logic/rtc_cal_set.sv
// Functional notes
// R1: Full time write clears hour, minute, second to zero, then loads host values.
// R2: Enabled alarm at midnight matches during that clearing and raises the interrupt.
// R3: Host should disable alarm interrupt before rewriting the time.
// R4: Host drops select between back-to-back commands.
// R5: A second command without select going low is ignored entirely.
// R6: Year kept and reported as two decimal digits, no century.
// R7: Year wraps from 99 to 00 and keeps running.
// R8: Two-digit year divisible by four, 00 included, is leap; February gets 29.
// R9: Divisible-by-four rule means 2100 is treated as leap.
// R10: Every field held in BCD, rolling over at its decimal limit.
`include "rtc_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module rtc_cal_set #(
  parameter int unsigned SEC_CYCLES = `RTC_SEC_CYCLES
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             cs_i,
  input  wire logic             sck_i,
  input  wire logic             sio_i,
  output logic                  sio_o,
  output logic                  sio_oe,
  output logic                  alarm_int,
  output rtc_pkg::rtc_time_t    time_o
);

  // ****************************************
  // Pin synchronisers, three flops each
  // ****************************************
  logic [2:0] cs_sync_q;
  logic [2:0] sck_sync_q;
  logic [2:0] sio_sync_q;
  logic       cs_q;
  logic       sck_q;
  logic       sio_q;
  logic       sck_prev_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cs_sync_q  <= 3'h0;
      sck_sync_q <= 3'h0;
      sio_sync_q <= 3'h7;
    end else begin
      cs_sync_q  <= {cs_sync_q[1:0], cs_i};
      sck_sync_q <= {sck_sync_q[1:0], sck_i};
      sio_sync_q <= {sio_sync_q[1:0], sio_i};
    end
  end

  // Accept a level once the second and third stages agree, keep last clock level
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cs_q  <= 1'b0;
      sck_q <= 1'b0;
      sio_q <= 1'b1;
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_q;
      if (cs_sync_q[2] == cs_sync_q[1]) cs_q <= cs_sync_q[2];
      if (sck_sync_q[2] == sck_sync_q[1]) sck_q <= sck_sync_q[2];
      if (sio_sync_q[2] == sio_sync_q[1]) sio_q <= sio_sync_q[2];
    end
  end

  logic sck_rise;
  logic sck_fall;

  assign sck_rise = cs_q && sck_q && !sck_prev_q;
  assign sck_fall = cs_q && !sck_q && sck_prev_q;

  // ****************************************
  // Serial frame: command byte, then data
  // ****************************************
  rtc_pkg::rtc_state_t state_q;
  logic [7:0]          shift_q;
  logic [2:0]          bit_q;
  logic [2:0]          byte_q;
  logic [7:0]          cmd_q;
  logic                byte_done;
  logic [7:0]          rx_byte;
  logic [2:0]          n_bytes;

  assign byte_done = sck_rise && (bit_q == 3'h7);
  assign rx_byte   = {sio_q, shift_q[7:1]};  // LSB first

  always_comb begin
    case (cmd_q)
      `RTC_CMD_TIME_WR:  n_bytes = `RTC_TIME_BYTES;
      `RTC_CMD_TIME_RD:  n_bytes = `RTC_TIME_BYTES;
      `RTC_CMD_ALARM_WR: n_bytes = `RTC_ALARM_BYTES;
      default:           n_bytes = `RTC_CTRL_BYTES;
    endcase
  end

  // Shift and bit counting within a frame
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shift_q <= 8'h00;
      bit_q   <= 3'h0;
    end else if (!cs_q) begin
      bit_q   <= 3'h0;
    end else if (sck_rise) begin
      shift_q <= rx_byte;
      bit_q   <= bit_q + 3'h1;
    end
  end

  logic cmd_valid;
  assign cmd_valid = (rx_byte == `RTC_CMD_TIME_WR) || (rx_byte == `RTC_CMD_TIME_RD) ||
                     (rx_byte == `RTC_CMD_ALARM_WR) || (rx_byte == `RTC_CMD_CTRL_WR);

  // Frame state machine
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= rtc_pkg::RTC_ST_IDLE;
      cmd_q   <= 8'h00;
      byte_q  <= 3'h0;
    end else if (!cs_q) begin
      state_q <= rtc_pkg::RTC_ST_IDLE;
    end else begin
      case (state_q)
        rtc_pkg::RTC_ST_IDLE: state_q <= rtc_pkg::RTC_ST_CMD;
        rtc_pkg::RTC_ST_CMD: begin
          if (byte_done) begin
            cmd_q   <= rx_byte;
            byte_q  <= 3'h0;
            state_q <= cmd_valid ? rtc_pkg::RTC_ST_DATA : rtc_pkg::RTC_ST_DONE;
          end
        end
        rtc_pkg::RTC_ST_DATA: begin
          if (byte_done) begin
            byte_q <= byte_q + 3'h1;
            if (byte_q == n_bytes - 3'h1) state_q <= rtc_pkg::RTC_ST_DONE;
          end
        end
        // R5: ignore until select low
        rtc_pkg::RTC_ST_DONE: state_q <= rtc_pkg::RTC_ST_DONE;
        default: state_q <= rtc_pkg::RTC_ST_IDLE;
      endcase
    end
  end

  logic in_data;
  logic wr_time;
  logic time_clr;
  logic wr_byte;

  assign in_data  = state_q == rtc_pkg::RTC_ST_DATA;
  assign wr_time  = in_data && (cmd_q == `RTC_CMD_TIME_WR);
  assign wr_byte  = in_data && byte_done;
  // R1: clear at command accept
  assign time_clr = (state_q == rtc_pkg::RTC_ST_CMD) && byte_done && (rx_byte == `RTC_CMD_TIME_WR);

  // ****************************************
  // Second tick from ref_clk
  // ****************************************
  logic [31:0] div_q;
  logic        tick;

  assign tick = (div_q == SEC_CYCLES - 1) && !wr_time;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_q <= 32'h0;
    end else if (div_q == SEC_CYCLES - 1) begin
      div_q <= 32'h0;
    end else begin
      div_q <= div_q + 32'h1;
    end
  end

  // ****************************************
  // Calendar counters
  // ****************************************
  logic [7:0] day_max;
  logic       leap;
  logic       w_sec;
  logic       w_min;
  logic       w_hour;
  logic       w_day;
  logic       w_month;

  // R8: two-digit year divisible by four
  // R9: no century exception
  assign leap = time_o.year[4] ? (time_o.year[3:0] == 4'h2 || time_o.year[3:0] == 4'h6)
                               : (time_o.year[3:0] == 4'h0 || time_o.year[3:0] == 4'h4 ||
                                  time_o.year[3:0] == 4'h8);

  // Month length, February from leap flag
  always_comb begin
    if (time_o.month == 8'h02) begin
      day_max = leap ? 8'h29 : 8'h28;
    end else if (time_o.month == 8'h04 || time_o.month == 8'h06 ||
                 time_o.month == 8'h09 || time_o.month == 8'h11) begin
      day_max = 8'h30;
    end else begin
      day_max = 8'h31;
    end
  end

  // R10: BCD fields, decimal limits
  // R1: hour, minute, second cleared then loaded
  rtc_bcd_counter u_sec (.ref_clk(ref_clk), .rst(rst), .inc(tick), .clr(time_clr), .ld_val(rx_byte),
    .load(wr_time && wr_byte && byte_q == `RTC_IDX_SEC), .min_val(8'h00), .max_val(8'h59),
    .q(time_o.sec), .wrap(w_sec));
  rtc_bcd_counter u_min (.ref_clk(ref_clk), .rst(rst), .inc(w_sec), .clr(time_clr), .ld_val(rx_byte),
    .load(wr_time && wr_byte && byte_q == `RTC_IDX_MIN), .min_val(8'h00), .max_val(8'h59),
    .q(time_o.min), .wrap(w_min));
  rtc_bcd_counter u_hour (.ref_clk(ref_clk), .rst(rst), .inc(w_min), .clr(time_clr), .ld_val(rx_byte),
    .load(wr_time && wr_byte && byte_q == `RTC_IDX_HOUR), .min_val(8'h00), .max_val(8'h23),
    .q(time_o.hour), .wrap(w_hour));
  // Date fields keep their value through the clear at a time write
  rtc_bcd_counter u_wday (.ref_clk(ref_clk), .rst(rst), .inc(w_hour), .clr(1'b0), .ld_val(rx_byte),
    .load(wr_time && wr_byte && byte_q == `RTC_IDX_WDAY), .min_val(8'h00), .max_val(8'h06),
    .q(time_o.wday), .wrap());
  rtc_bcd_counter u_day (.ref_clk(ref_clk), .rst(rst), .inc(w_hour), .clr(1'b0), .ld_val(rx_byte),
    .load(wr_time && wr_byte && byte_q == `RTC_IDX_DAY), .min_val(8'h01), .max_val(day_max),
    .q(time_o.day), .wrap(w_day));
  rtc_bcd_counter u_month (.ref_clk(ref_clk), .rst(rst), .inc(w_day), .clr(1'b0), .ld_val(rx_byte),
    .load(wr_time && wr_byte && byte_q == `RTC_IDX_MONTH), .min_val(8'h01), .max_val(8'h12),
    .q(time_o.month), .wrap(w_month));
  // R6: two digits only
  // R7: wrap 99 to 00
  rtc_bcd_counter u_year (.ref_clk(ref_clk), .rst(rst), .inc(w_month), .clr(1'b0), .ld_val(rx_byte),
    .load(wr_time && wr_byte && byte_q == `RTC_IDX_YEAR), .min_val(8'h00), .max_val(8'h99),
    .q(time_o.year), .wrap());

  // ****************************************
  // Alarm and interrupt
  // ****************************************
  logic [7:0] al_hour_q;
  logic [7:0] al_min_q;
  logic       aie_q;
  logic       match;
  logic       match_q;
  logic       ctrl_wr;

  assign ctrl_wr = wr_byte && (cmd_q == `RTC_CMD_CTRL_WR);

  // Alarm time and enable registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      al_hour_q <= 8'h00;
      al_min_q  <= 8'h00;
      aie_q     <= 1'b0;
    end else if (wr_byte && cmd_q == `RTC_CMD_ALARM_WR) begin
      if (byte_q == 3'h0) al_hour_q <= rx_byte;
      else al_min_q <= rx_byte;
    end else if (ctrl_wr) begin
      aie_q <= rx_byte[`RTC_CTRL_AIE_BIT];
    end
  end

  // R2: zeroed time matches midnight alarm
  assign match = aie_q && (time_o.hour == al_hour_q) && (time_o.min == al_min_q) &&
                 (time_o.sec == 8'h00);

  // Sticky interrupt; new match wins over clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      match_q   <= 1'b0;
      alarm_int <= 1'b0;
    end else begin
      match_q <= match;
      if (match && !match_q) alarm_int <= 1'b1;
      else if (ctrl_wr) alarm_int <= 1'b0;
    end
  end

  // ****************************************
  // Read-back shifter, open drain data
  // ****************************************
  logic [55:0] tx_q;

  // Snapshot on every command byte, shift on falling clock during a read, release on the fall after the last bit
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_q   <= 56'h0;
      sio_oe <= 1'b0;
      sio_o  <= 1'b0;
    end else if (!cs_q || (sck_fall && state_q == rtc_pkg::RTC_ST_DONE)) begin
      sio_oe <= 1'b0;
    end else if (state_q == rtc_pkg::RTC_ST_CMD && byte_done) begin
      tx_q <= {time_o.sec, time_o.min, time_o.hour, time_o.wday,
               time_o.day, time_o.month, time_o.year};
    end else if (sck_fall && in_data && cmd_q == `RTC_CMD_TIME_RD) begin
      sio_oe <= !tx_q[0];
      tx_q   <= {1'b0, tx_q[55:1]};
    end
  end

endmodule : rtc_cal_set

`default_nettype wire

//--- testbench/rtc_cal_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Calendar checker
// ****************************************
module rtc_cal_monitor #(
  parameter int unsigned SEC_CYCLES = 50
) (
  input wire logic               ref_clk,
  input wire logic               rst,
  input wire logic               cs_i,
  input wire logic               sio_oe,
  input wire logic               alarm_int,
  input wire rtc_pkg::rtc_time_t time_o
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Leap test on a BCD year: odd tens need units 2 or 6
  function automatic logic leap(input logic [7:0] y);
    return y[1:0] == {y[4], 1'b0};
  endfunction : leap

  property p_time_bcd;
    time_o.sec <= 8'h59 && time_o.min <= 8'h59 && time_o.hour <= 8'h23 &&
    time_o.sec[3:0] <= 4'h9 && time_o.min[3:0] <= 4'h9 && time_o.hour[3:0] <= 4'h9;
  endproperty
  a_time_bcd: assert property (p_time_bcd) else $error("time field out of decimal range");

  property p_year_bcd;
    time_o.year[7:4] <= 4'h9 && time_o.year[3:0] <= 4'h9;
  endproperty
  a_year_bcd: assert property (p_year_bcd) else $error("year not two decimal digits");

  property p_year_wrap;
    $past(time_o.month) == 8'h12 && time_o.month == 8'h01 && $past(time_o.year) == 8'h99 |-> time_o.year == 8'h00;
  endproperty
  a_year_wrap: assert property (p_year_wrap) else $error("year did not wrap to 00");

  property p_feb_leap;
    $past(time_o.month) == 8'h02 && $past(time_o.day) == 8'h28 && time_o.day != 8'h28
      |-> time_o.day == (leap(time_o.year) ? 8'h29 : 8'h01);
  endproperty
  a_feb_leap: assert property (p_feb_leap) else $error("wrong day after 28 february");

  property p_year00_leap;
    $changed(time_o.day) && time_o.year == 8'h00 && $past(time_o.month) == 8'h02 && $past(time_o.day) == 8'h28
      |=> time_o.day == 8'h29 && time_o.month == 8'h02;
  endproperty
  a_year00_leap: assert property (p_year00_leap) else $error("year 00 not leap");

  property p_clear_date;
    (time_o.hour | time_o.min | time_o.sec) == 8'h00 && $past(time_o.sec) != 8'h59 && $past(time_o.sec) != 8'h00
      |-> $stable(time_o.year) && $stable(time_o.month) && $stable(time_o.day);
  endproperty
  a_clear_date: assert property (p_clear_date) else $error("time clear touched date");

  property p_alarm_sec;
    $rose(alarm_int) |-> $past(time_o.sec) == 8'h00;
  endproperty
  a_alarm_sec: assert property (p_alarm_sec) else $error("alarm raised off second zero");

  property p_oe_idle;
    !cs_i [*8] |-> !sio_oe;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("data line driven outside frame");
endmodule : rtc_cal_monitor

bind rtc_cal_set rtc_cal_monitor #(.SEC_CYCLES(SEC_CYCLES)) u_monitor (.ref_clk(ref_clk), .rst(rst), .cs_i(cs_i),
  .sio_oe(sio_oe), .alarm_int(alarm_int), .time_o(time_o));
`default_nettype wire

//--- testbench/rtc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Host on the three-wire link
// ****************************************
module rtc_host_model (
  output var logic  cs_o,
  output var logic  sck_o,
  output wire logic sio_w,
  input wire logic  sio_oe
);
  logic drv_en;
  logic drv_bit;

  // Open-drain data wire with pull-up
  assign sio_w = (drv_en ? drv_bit : 1'b1) & ~sio_oe;

  // Idle link, clock stands low
  initial begin
    cs_o = 1'b0;
    sck_o = 1'b0;
    drv_en = 1'b0;
    drv_bit = 1'b0;
  end

  // Select high on a falling edge of the bench clock
  task automatic begin_frame();
    #4 cs_o = 1'b1;
    #40;
  endtask : begin_frame

  // One byte, LSB first, 32 ns link period
  task automatic xfer(input logic [7:0] wr, input logic wr_en, output logic [7:0] rd);
    for (int i = 0; i < 8; i++) begin
      drv_en = wr_en;
      drv_bit = wr[i];
      #16 sck_o = 1'b1;
      #16 rd[i] = sio_w;
      sck_o = 1'b0;
    end
  endtask : xfer

  task automatic end_frame();
    #16 drv_en = 1'b0;
    cs_o = 1'b0;
    #48;
  endtask : end_frame
endmodule : rtc_host_model
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Calendar and time-set bench
// ****************************************
module testbench;
  localparam int unsigned SEC_CYC = 50;
  logic               ref_clk, rst, cs, sck, sio_w, sio_o, sio_oe, alarm_int;
  rtc_pkg::rtc_time_t time_o;
  logic [31:0]        lfsr_q = 32'h9a458eb0;
  logic [7:0]         rd;
  int                 fail_count = 0, total_checks = 0, cycles = 0, yr, mo;

  rtc_cal_set #(.SEC_CYCLES(SEC_CYC)) u_dut (.ref_clk(ref_clk), .rst(rst), .cs_i(cs), .sck_i(sck), .sio_i(sio_w),
    .sio_o(sio_o), .sio_oe(sio_oe), .alarm_int(alarm_int), .time_o(time_o));
  rtc_host_model u_host (.cs_o(cs), .sck_o(sck), .sio_w(sio_w), .sio_oe(sio_oe));

  // 250 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run

  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      complete_run();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [7:0] to_bcd(input int n);
    return {4'(n / 10), 4'(n % 10)};
  endfunction : to_bcd

  function automatic int dim(input int m, input int y);
    if (m == 2) return (y % 4 == 0) ? 29 : 28;
    return (m == 4 || m == 6 || m == 9 || m == 11) ? 30 : 31;
  endfunction : dim

  // Control byte write
  task automatic ctrl(input logic [7:0] v);
    u_host.begin_frame();
    u_host.xfer(8'h04, 1'b1, rd);
    u_host.xfer(v, 1'b1, rd);
    u_host.end_frame();
  endtask : ctrl

  // Full time write, probing the clear after the command byte
  task automatic write_time(input rtc_pkg::rtc_time_t t, input logic exp_int, input logic keep);
    logic [7:0] old_year;
    old_year = time_o.year;
    u_host.begin_frame();
    u_host.xfer(8'h01, 1'b1, rd);
    repeat (6) @(negedge ref_clk);
    check("hms cleared", time_o.hour | time_o.min | time_o.sec, 8'h00);
    check("year kept", time_o.year, old_year);
    check("alarm on clear", {7'h00, alarm_int}, {7'h00, exp_int});
    for (int i = 0; i < 7; i++) u_host.xfer(t[55-8*i -: 8], 1'b1, rd);
    if (!keep) u_host.end_frame();
  endtask : write_time

  // Set last second of a day, wait for the rollover
  task automatic roll(input int y, input int m, input int d);
    int ny, nm, nd;
    rtc_pkg::rtc_time_t t;
    t = {to_bcd(y), to_bcd(m), to_bcd(d), 8'h00, 8'h23, 8'h59, 8'h59};
    write_time(t, 1'b0, 1'b0);
    for (int i = 0; i < 600 && time_o.day === t.day; i++) @(negedge ref_clk);
    nd = d + 1;
    nm = m;
    ny = y;
    if (nd > dim(m, y)) begin
      nd = 1;
      nm = m % 12 + 1;
      ny = (m == 12) ? (y + 1) % 100 : y;
    end
    check("day", time_o.day, to_bcd(nd));
    check("month", time_o.month, to_bcd(nm));
    check("year", time_o.year, to_bcd(ny));
    check("midnight", time_o.hour | time_o.min | time_o.sec, 8'h00);
  endtask : roll

  // Main sequence
  initial begin
    rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk) rst = 1'b0;
    repeat (10) @(negedge ref_clk);
    // Alarm at midnight, interrupt enabled
    u_host.begin_frame();
    u_host.xfer(8'h03, 1'b1, rd);
    u_host.xfer(8'h00, 1'b1, rd);
    u_host.xfer(8'h00, 1'b1, rd);
    u_host.end_frame();
    ctrl(8'h01);
    write_time({8'h24, 8'h05, 8'h17, 8'h03, 8'h12, 8'h34, 8'h56}, 1'b1, 1'b0);
    check("alarm held", {7'h00, alarm_int}, 8'h01);
    ctrl(8'h00);
    check("alarm cleared", {7'h00, alarm_int}, 8'h00);
    // Second command without select low
    write_time({8'h42, 8'h07, 8'h09, 8'h01, 8'h10, 8'h20, 8'h30}, 1'b0, 1'b1);
    u_host.xfer(8'h01, 1'b1, rd);
    for (int i = 0; i < 7; i++) u_host.xfer(8'h55, 1'b1, rd);
    u_host.end_frame();
    check("year after drop", time_o.year, 8'h42);
    u_host.begin_frame();
    u_host.xfer(8'h02, 1'b1, rd);
    u_host.xfer(8'h00, 1'b0, rd);
    check("read year", rd, 8'h42);
    u_host.xfer(8'h00, 1'b0, rd);
    check("read month", rd, 8'h07);
    u_host.end_frame();
    roll(0, 2, 28);
    check("year 00 leap", time_o.day, 8'h29);
    roll(4, 2, 28);
    roll(96, 2, 28);
    roll(1, 2, 28);
    roll(50, 4, 30);
    roll(99, 12, 31);
    repeat (4) begin
      lfsr_q = lfsr(lfsr_q);
      yr = int'(lfsr_q % 100);
      lfsr_q = lfsr(lfsr_q);
      mo = int'(lfsr_q % 10) + 1;
      roll(yr, mo, dim(mo, yr));
    end
    complete_run();
  end
endmodule : testbench
`default_nettype wire
